// ### hw/usrx_consts.vh
/*
 * Constants of the serial port: register offsets, field positions,
 * writable masks and reset values.
 * Assumes byte addressing of 16-bit registers on a plain register port.
 */
`ifndef USRX_CONSTS_VH
`define USRX_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define USRX_OFS_MODE    12'h220
`define USRX_OFS_STA     12'h222
`define USRX_OFS_TXH     12'h224
`define USRX_OFS_RXD     12'h226
`define USRX_OFS_BRG     12'h228

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define USRX_RST_MODE    16'h0000
`define USRX_RST_STA     16'h0110
`define USRX_RST_RXD     16'h0000
`define USRX_RST_BRG     16'h0000
`define USRX_WMSK_MODE   16'hb4ff
`define USRX_WMSK_STA    16'hece0

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define USRX_M_EN        15
`define USRX_M_LPBACK    6
`define USRX_M_RXINV     4
`define USRX_M_BRGH      3
`define USRX_M_PDSEL_HI  2
`define USRX_M_PDSEL_LO  1
`define USRX_M_STSEL     0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define USRX_S_TXEN      10
`define USRX_S_TXBF      9
`define USRX_S_TSE       8
`define USRX_S_ADDEN     5
`define USRX_S_RECEIVER_IDLE_FLAG     4
`define USRX_S_PARITY_ERROR_FLAG      3
`define USRX_S_FRAMING_ERROR_FLAG      2
`define USRX_S_OVERRUN_ERROR_FLAG      1
`define USRX_S_RXDA      0

// ----------------------------------------
// Oversampling
// ----------------------------------------
`define USRX_OS_STD      5'h10
`define USRX_OS_HI       5'h04

`endif

// ### hw/usrx_top.v
/*
 * Serial port receive status and register map, with a simple
 * transmitter and a receive queue FIFO.
 * Assumes one clock, software on a plain strobe port, and a serial line
 * asynchronous to clk (synchronised inside).
 */
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "usrx_consts.vh"

// ----------------------------------------
// Receive queue
// ----------------------------------------
module usrx_fifo #(
	parameter W     = 11,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire          clk,
	input  wire          reset,
	input  wire          flush,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);
	reg [W-1:0]  mem [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0]   cnt_q;
	wire         push;
	wire         pop;

	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rp_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge clk)
	begin
		if (push)
			mem[wp_q] <= in_data;
	end

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// Notes on behaviour
// - Receiver idle flag reads one when no character is arriving, zero otherwise.
// - Parity error flag belongs to the character at the queue head.
// - Framing error flag belongs to the character at the queue head.
// - Overrun flag set by hardware on overflow; software may only clear it.
// - Clearing a set overrun flag empties the queue and returns the receiver to idle.
// - Data available flag reads one while the queue holds a character.
// - After reset the status register reads with only idle and shift-empty set.
// - After reset receive, mode and divisor read zero; transmit holding always reads zero.
// - Unimplemented bits read zero and ignore writes.
// - Five registers at consecutive word offsets from the mode register; full divisor.
// - Reading receive data advances the queue to the next character and flags.
// - Queue holds four characters and is full at four.
module usrx_top #(
	parameter RX_DEPTH = 4,
	parameter RX_AW    = 2
) (
	input  wire        clk,
	input  wire        reset,
	input  wire [11:0] addr,
	input  wire [15:0] wr_data,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [15:0] rd_data_q,
	input  wire        rx_pin,
	output reg         tx_q
);
	localparam S_IDLE  = 3'h0;
	localparam S_START = 3'h1;
	localparam S_DATA  = 3'h2;
	localparam S_PAR   = 3'h3;
	localparam S_STOP  = 3'h4;
	localparam S_STOP2 = 3'h5;
	localparam S_TAIL  = 3'h6;

	// ----------------------------------------
	// Registers and derived controls
	// ----------------------------------------
	reg  [15:0] mode_q;
	reg  [15:0] sta_w_q;
	reg  [15:0] brg_q;
	reg         overrun_error_flag_q;
	reg  [15:0] bcnt_q;
	reg         rx_s1_q;
	reg         rx_s2_q;

	wire        en     = mode_q[`USRX_M_EN];
	wire        brgh   = mode_q[`USRX_M_BRGH];
	wire [1:0]  pdsel  = mode_q[`USRX_M_PDSEL_HI:`USRX_M_PDSEL_LO];
	wire        nine   = (pdsel == 2'h3);
	wire        par_on = (pdsel == 2'h1) || (pdsel == 2'h2);
	wire        odd    = (pdsel == 2'h2);
	wire        txen   = sta_w_q[`USRX_S_TXEN];
	wire [4:0]  osr    = brgh ? `USRX_OS_HI : `USRX_OS_STD;
	wire [3:0]  lastb  = nine ? 4'h8 : 4'h7;
	wire        tick   = en && (bcnt_q == 16'h0000);
	wire        wr_sta = wr_en && (addr == `USRX_OFS_STA);
	wire        rx_in;

	// Oversampling clock: one tick every divisor+1 cycles
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			bcnt_q <= 16'h0000;
		else if (!en || bcnt_q == 16'h0000)
			bcnt_q <= brg_q;
		else
			bcnt_q <= bcnt_q - 1'b1;
	end

	// Line input passes two flops before use
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end
		else
		begin
			rx_s1_q <= rx_pin;
			rx_s2_q <= rx_s1_q;
		end
	end

	assign rx_in = mode_q[`USRX_M_LPBACK] ? tx_q : (rx_s2_q ^ mode_q[`USRX_M_RXINV]);

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	reg  [2:0]  rs_q;
	reg  [4:0]  ros_q;
	reg  [3:0]  rbit_q;
	reg  [8:0]  rsh_q;
	reg         rpar_q;
	wire        rsamp = tick && (ros_q == 5'h00);
	wire        pbad  = par_on && ((^rsh_q[7:0]) ^ rpar_q ^ odd);
	wire        keep  = !(nine && sta_w_q[`USRX_S_ADDEN] && !rsh_q[8]);
	wire        done  = rsamp && (rs_q == S_STOP) && keep;
	wire        q_ready;
	wire        q_valid;
	wire [10:0] q_head;
	wire        ovf   = done && !q_ready;
	wire        flush = wr_sta && overrun_error_flag_q && !wr_data[`USRX_S_OVERRUN_ERROR_FLAG] && !ovf;
	wire        pop   = rd_en && (addr == `USRX_OFS_RXD) && q_valid;

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rs_q   <= S_IDLE;
			ros_q  <= 5'h00;
			rbit_q <= 4'h0;
			rsh_q  <= 9'h000;
			rpar_q <= 1'b0;
		end
		else if (!en || flush)
			rs_q <= S_IDLE;
		else if (rs_q == S_IDLE)
		begin
			if (!rx_in)
			begin
				rs_q  <= S_START;
				ros_q <= {1'b0, osr[4:1]} - 1'b1;
				rsh_q <= 9'h000;
			end
		end
		else if (tick)
		begin
			if (ros_q != 5'h00)
				ros_q <= ros_q - 1'b1;
			else
			begin
				ros_q <= osr - 1'b1;
				case (rs_q)
				S_START:
				begin
					rs_q   <= rx_in ? S_IDLE : S_DATA;
					rbit_q <= 4'h0;
				end
				S_DATA:
				begin
					rsh_q[rbit_q] <= rx_in;
					rbit_q        <= rbit_q + 1'b1;
					if (rbit_q == lastb)
						rs_q <= par_on ? S_PAR : S_STOP;
				end
				S_PAR:
				begin
					rpar_q <= rx_in;
					rs_q   <= S_STOP;
				end
				default:
					rs_q <= S_IDLE;
				endcase
			end
		end
	end

	// Full queue refuses the new character; queued ones stay intact
	usrx_fifo #(
		.W     (11),
		.DEPTH (RX_DEPTH),
		.AW    (RX_AW)
	) u_rxq (
		.clk       (clk),
		.reset     (reset),
		.flush     (flush),
		.in_valid  (done),
		.in_ready  (q_ready),
		.in_data   ({pbad, !rx_in, rsh_q}),
		.out_valid (q_valid),
		.out_ready (pop),
		.out_data  (q_head)
	);

	// Overrun: set wins over a clear in the same cycle
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			overrun_error_flag_q <= 1'b0;
		else if (ovf)
			overrun_error_flag_q <= 1'b1;
		else if (wr_sta && !wr_data[`USRX_S_OVERRUN_ERROR_FLAG])
			overrun_error_flag_q <= 1'b0;
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	reg  [2:0]  ts_q;
	reg  [4:0]  tos_q;
	reg  [3:0]  tbit_q;
	reg  [8:0]  tsh_q;
	reg  [8:0]  thold_q;
	reg         thf_q;
	wire        tsamp = tick && (tos_q == 5'h00);
	wire        tse   = (ts_q == S_IDLE) && !thf_q;

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ts_q    <= S_IDLE;
			tos_q   <= 5'h00;
			tbit_q  <= 4'h0;
			tsh_q   <= 9'h000;
			thold_q <= 9'h000;
			thf_q   <= 1'b0;
			tx_q    <= 1'b1;
		end
		else if (!en || !txen)
		begin
			// Disabling aborts the character and drops the holding word
			ts_q  <= S_IDLE;
			thf_q <= 1'b0;
			tx_q  <= 1'b1;
		end
		else
		begin
			if (wr_en && addr == `USRX_OFS_TXH && !thf_q)
			begin
				thold_q <= wr_data[8:0];
				thf_q   <= 1'b1;
			end
			if (ts_q == S_IDLE)
			begin
				if (thf_q)
				begin
					tsh_q  <= thold_q;
					thf_q  <= 1'b0;
					ts_q   <= S_START;
					tos_q  <= osr - 1'b1;
					tbit_q <= 4'h0;
					tx_q   <= 1'b0;
				end
			end
			else if (tick)
			begin
				if (!tsamp)
					tos_q <= tos_q - 1'b1;
				else
				begin
					tos_q <= osr - 1'b1;
					case (ts_q)
					S_START, S_DATA:
					begin
						tx_q   <= tsh_q[tbit_q];
						tbit_q <= tbit_q + 1'b1;
						if (tbit_q == lastb)
							ts_q <= par_on ? S_PAR : S_STOP;
						else
							ts_q <= S_DATA;
					end
					S_PAR:
					begin
						tx_q <= (^tsh_q[7:0]) ^ odd;
						ts_q <= S_STOP;
					end
					// Each stop bit holds the line high for a full bit before the next start
					S_STOP:
					begin
						tx_q <= 1'b1;
						ts_q <= mode_q[`USRX_M_STSEL] ? S_STOP2 : S_TAIL;
					end
					S_STOP2:
					begin
						tx_q <= 1'b1;
						ts_q <= S_TAIL;
					end
					default:
					begin
						tx_q <= 1'b1;
						ts_q <= S_IDLE;
					end
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	wire [15:0] sta_rd = (sta_w_q & `USRX_WMSK_STA)
	                   | {6'h00, thf_q, tse, 8'h00}
	                   | {11'h000, (rs_q == S_IDLE),
	                      q_valid && q_head[10],
	                      q_valid && q_head[9],
	                      overrun_error_flag_q,
	                      q_valid};

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mode_q  <= `USRX_RST_MODE;
			sta_w_q <= `USRX_RST_STA & `USRX_WMSK_STA;
			brg_q   <= `USRX_RST_BRG;
		end
		else if (wr_en)
		begin
			case (addr)
			`USRX_OFS_MODE:
				mode_q <= wr_data & `USRX_WMSK_MODE;
			`USRX_OFS_STA:
				sta_w_q <= wr_data & `USRX_WMSK_STA;
			`USRX_OFS_BRG:
				brg_q <= wr_data;
			default:
				brg_q <= brg_q;
			endcase
		end
	end

	always @(posedge clk or posedge reset)
	begin
		if (reset)
			rd_data_q <= 16'h0000;
		else if (rd_en)
		begin
			case (addr)
			`USRX_OFS_MODE:
				rd_data_q <= mode_q;
			`USRX_OFS_STA:
				rd_data_q <= sta_rd;
			`USRX_OFS_RXD:
				rd_data_q <= q_valid ? {7'h00, q_head[8:0]} : `USRX_RST_RXD;
			`USRX_OFS_BRG:
				rd_data_q <= brg_q;
			default:
				rd_data_q <= 16'h0000;
			endcase
		end
		else
			rd_data_q <= 16'h0000;
	end
endmodule

// ### dv/usrx_monitor.sv
/*
 * Port checker for the serial port register map.
 * Assumes the plain strobe port and one reset per run.
 */
`timescale 1ns/10ps
`include "usrx_consts.vh"
module usrx_monitor (
	input wire        clk,
	input wire        reset,
	input wire [11:0] addr,
	input wire [15:0] wr_data,
	input wire        wr_en,
	input wire        rd_en,
	input wire [15:0] rd_data_q,
	input wire        rx_pin,
	input wire        tx_q
);
	// ----------------------------------------
	// Helper: no write seen since reset
	// ----------------------------------------
	// Receiver stays off until a mode write, so reset values hold until the first write
	reg seen_wr_q;
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			seen_wr_q <= 1'b0;
		else if (wr_en)
			seen_wr_q <= 1'b1;
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_RD_QUIET: assert property (@(posedge clk) disable iff (reset)
		!$past(rd_en) |-> rd_data_q == 16'h0000) else $error("read data outside answer");
	AST_UNMAPPED: assert property (@(posedge clk) disable iff (reset)
		rd_en && addr != `USRX_OFS_MODE && addr != `USRX_OFS_STA && addr != `USRX_OFS_TXH
		&& addr != `USRX_OFS_RXD && addr != `USRX_OFS_BRG |=> rd_data_q == 16'h0000)
		else $error("unmapped read not zero");
	AST_RXD_UPPER: assert property (@(posedge clk) disable iff (reset)
		rd_en && addr == `USRX_OFS_RXD |=> rd_data_q[15:9] == 7'h00) else $error("receive upper bits set");
	AST_STA_UNIMPL: assert property (@(posedge clk) disable iff (reset)
		rd_en && addr == `USRX_OFS_STA |=> !rd_data_q[12]) else $error("status bit 12 set");
	AST_MODE_UNIMPL: assert property (@(posedge clk) disable iff (reset)
		rd_en && addr == `USRX_OFS_MODE |=> (rd_data_q & 16'h4b00) == 16'h0000) else $error("mode gap bits set");
	AST_RESET_STA: assert property (@(posedge clk) disable iff (reset)
		rd_en && addr == `USRX_OFS_STA && !seen_wr_q |=> rd_data_q == 16'h0110) else $error("status reset value");
	AST_RESET_ZERO: assert property (@(posedge clk) disable iff (reset)
		rd_en && !seen_wr_q && (addr == `USRX_OFS_MODE || addr == `USRX_OFS_RXD || addr == `USRX_OFS_BRG)
		|=> rd_data_q == 16'h0000) else $error("register reset value not zero");
	AST_BRG_FULL: assert property (@(posedge clk) disable iff (reset)
		wr_en && addr == `USRX_OFS_BRG ##1 rd_en && !wr_en && addr == `USRX_OFS_BRG
		|=> rd_data_q == $past(wr_data, 2)) else $error("divisor readback");
	AST_OVR_STICKY: assert property (@(posedge clk) disable iff (reset)
		rd_en && !wr_en && addr == `USRX_OFS_STA ##1 rd_en && !wr_en && addr == `USRX_OFS_STA && rd_data_q[1]
		|=> rd_data_q[1]) else $error("overrun cleared by hardware");
endmodule
bind usrx_top usrx_monitor mon (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
	.rd_en(rd_en), .rd_data_q(rd_data_q), .rx_pin(rx_pin), .tx_q(tx_q));

// ### dv/usrx_peer.sv
/*
 * Remote serial transmitter driving the receive line.
 * Assumes BIT_CLK clocks per bit, 8 data bits, even parity.
 */
`timescale 1ns/10ps
module usrx_peer #(
	parameter BIT_CLK = 4
) (
	input  wire clk,
	output reg  line
);
	integer i;
	initial line = 1'b1;
	// Start, data LSB first, parity, stop, then two idle bits so the char lands
	task send(input [7:0] d, input bad_par, input bad_stop);
		reg [10:0] f;
		begin
			f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
			for (i = 0; i < 13; i = i + 1)
			begin
				line <= (i < 11) ? f[i] : 1'b1;
				repeat (BIT_CLK) @(posedge clk);
			end
		end
	endtask
endmodule

// ### dv/testbench.sv
/*
 * Register-level tests of the serial receive status and map.
 * Assumes divisor 0 and 4x oversampling, so one bit is 4 clocks.
 */
`timescale 1ns/10ps
`include "usrx_consts.vh"
module testbench;
	reg         clk;
	reg         reset;
	reg  [11:0] addr;
	reg  [15:0] wr_data;
	reg         wr_en;
	reg         rd_en;
	wire [15:0] rd_data_q;
	wire        rx_pin;
	wire        tx_q;
	integer     err_count;
	integer     total_checks;
	integer     cyc;
	integer     k;
	initial clk = 1'b0;
	always #20 clk = ~clk;
	usrx_top dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data_q(rd_data_q), .rx_pin(rx_pin), .tx_q(tx_q));
	usrx_peer #(.BIT_CLK(4)) peer (.clk(clk), .line(rx_pin));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task chk(input [15:0] got, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp)
			begin
				err_count = err_count + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Both tasks return 1 ns after an edge so calls chain back to back
	task wr(input [11:0] a, input [15:0] d);
		begin
			addr <= a;
			wr_data <= d;
			wr_en <= 1'b1;
			@(posedge clk);
			wr_en <= 1'b0;
			#1;
		end
	endtask
	task rd(input [11:0] a, input [15:0] e);
		begin
			addr <= a;
			rd_en <= 1'b1;
			@(posedge clk);
			rd_en <= 1'b0;
			#1;
			chk(rd_data_q, e);
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			err_count = err_count + 1;
			close_out;
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		err_count = 0;
		total_checks = 0;
		cyc = 0;
		reset = 1'b1;
		addr = 12'h000;
		wr_data = 16'h0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		rd(`USRX_OFS_STA, 16'h0110);
		rd(`USRX_OFS_MODE, 16'h0000);
		rd(`USRX_OFS_RXD, 16'h0000);
		rd(`USRX_OFS_BRG, 16'h0000);
		rd(12'h22a, 16'h0000);
		wr(`USRX_OFS_BRG, 16'hffff);
		rd(`USRX_OFS_BRG, 16'hffff);
		wr(`USRX_OFS_BRG, 16'h0000);
		wr(`USRX_OFS_RXD, 16'hffff);
		wr(`USRX_OFS_MODE, 16'h4b00);
		rd(`USRX_OFS_MODE, 16'h0000);
		wr(`USRX_OFS_MODE, 16'h800a);
		rd(`USRX_OFS_MODE, 16'h800a);
		fork
			peer.send(8'h5a, 1'b0, 1'b0);
			begin
				repeat (16) @(posedge clk);
				#1;
				rd(`USRX_OFS_STA, 16'h0100);
			end
		join
		peer.send(8'h33, 1'b1, 1'b0);
		peer.send(8'hc1, 1'b0, 1'b1);
		rd(`USRX_OFS_STA, 16'h0111);
		rd(`USRX_OFS_RXD, 16'h005a);
		rd(`USRX_OFS_STA, 16'h0119);
		rd(`USRX_OFS_RXD, 16'h0033);
		rd(`USRX_OFS_STA, 16'h0115);
		rd(`USRX_OFS_RXD, 16'h00c1);
		rd(`USRX_OFS_STA, 16'h0110);
		rd(`USRX_OFS_RXD, 16'h0000);
		for (k = 1; k <= 5; k = k + 1)
			peer.send(k[7:0], 1'b0, 1'b0);
		rd(`USRX_OFS_STA, 16'h0113);
		rd(`USRX_OFS_STA, 16'h0113);
		wr(`USRX_OFS_STA, 16'h0002);
		for (k = 1; k <= 4; k = k + 1)
			rd(`USRX_OFS_RXD, k[15:0]);
		rd(`USRX_OFS_RXD, 16'h0000);
		rd(`USRX_OFS_STA, 16'h0112);
		peer.send(8'h7e, 1'b0, 1'b0);
		rd(`USRX_OFS_STA, 16'h0113);
		wr(`USRX_OFS_STA, 16'h0000);
		rd(`USRX_OFS_STA, 16'h0110);
		rd(`USRX_OFS_RXD, 16'h0000);
		peer.send(8'h42, 1'b0, 1'b0);
		rd(`USRX_OFS_RXD, 16'h0042);
		// Loopback with odd parity: the transmitter feeds the receiver
		wr(`USRX_OFS_STA, 16'h0400);
		wr(`USRX_OFS_MODE, 16'h804c);
		wr(`USRX_OFS_TXH, 16'h00a5);
		rd(`USRX_OFS_STA, 16'h0610);
		chk({15'h0000, tx_q}, 16'h0000);
		repeat (60) @(posedge clk);
		#1;
		rd(`USRX_OFS_STA, 16'h0511);
		chk({15'h0000, tx_q}, 16'h0001);
		rd(`USRX_OFS_RXD, 16'h00a5);
		close_out;
	end
endmodule
